/* hdl/pmic_config_bank.sv */
// Configuration bank at 0x108..0x10D of a power management device, and
// the control levels that its bits steer.
// Assumes the two-wire control interface decodes host transfers into the
// byte register port below; all inputs are synchronous to sys_clk.
`default_nettype none

module pmic_config_bank (
  input  wire logic                           sys_clk,
  input  wire logic                           nrst,
  // Byte register port from the two-wire interface
  input  wire logic [cfg_bank_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [cfg_bank_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output var  logic [cfg_bank_pkg::DATA_W-1:0] reg_rdata,
  output var  logic                           reg_rvalid,
  // Buck switching clock phase and rail discharge
  output var  logic                           periph_buck_phase_flip,
  output var  logic                           io_buck_phase_flip,
  output var  logic                           mem_buck_phase_flip,
  output var  logic                           proc_buck_phase_flip,
  output var  logic                           core_buck_a_phase_flip,
  output var  logic                           core_buck_b_phase_flip,
  output var  logic                           rail_active_drain,
  // Feedback outputs and sense routing
  input  wire logic                           feedback3_event,
  output var  logic                           feedback3_pin,
  input  wire logic                           power_good,
  output var  logic                           feedback2_pin_out,
  output var  logic                           feedback2_pin_oe_n,
  output var  logic                           sense_to_feedback2,
  output var  logic                           sense_to_core_switch,
  // Reset and interrupt pins
  input  wire logic                           reset_request,
  output var  logic                           reset_out_n,
  input  wire logic                           irq_pending,
  input  wire logic                           power_active,
  output var  logic                           interrupt_out_n,
  // Two-wire interface speed
  output var  logic                           permanent_high_speed,
  output var  logic                           fast_plus_timing,
  // OTP reload of system enable
  input  wire logic                           otp_second_read,
  input  wire logic                           otp_system_en,
  output var  logic                           system_en,
  // Power-up rail enables and LDO bypass
  input  wire logic                           powering_up,
  input  wire logic [7:0]                     buck_conf_en,
  output var  logic [7:0]                     buck_rail_en,
  input  wire logic [4:0]                     ldo_conf_en,
  output var  logic [4:0]                     ldo_rail_en,
  output var  logic [3:0]                     ldo_bypass,
  // Buck joining and current modes
  output var  logic                           io_buck_ctrl_off,
  output var  logic                           core_b_ctrl_off,
  output var  logic                           core_a_full_current,
  output var  logic                           core_b_full_current,
  output var  logic                           proc_full_current,
  // LDO8 motor driver and PWM clock
  output var  logic                           ldo8_motor_select,
  output var  logic                           pwm_clk_tick,
  output var  logic                           pwm_period_tick
);

  import cfg_bank_pkg::*;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // True when the address falls inside this bank
  function automatic logic in_bank(input logic [ADDR_W-1:0] addr);
    in_bank = (addr >= ADDR_BUCK_CLOCK_PHASE_CFG) && (addr <= ADDR_BUCK_JOIN_MODE_CFG);
  endfunction

  // Register index of an in-bank address
  function automatic logic [2:0] bank_index(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] diff;
    diff       = addr - ADDR_BUCK_CLOCK_PHASE_CFG;
    bank_index = diff[2:0];
  endfunction

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] cfg_q [NUM_REGS];  // All six registers, index order

  // Reserved bits are stored and read back but drive nothing below
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          cfg_q[gi] <= CFG_RESET_VALUE;
        end else if (reg_wr && in_bank(reg_addr) && (bank_index(reg_addr) == 3'(gi))) begin
          cfg_q[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  // Read answer one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (in_bank(reg_addr)) begin
          reg_rdata <= cfg_q[bank_index(reg_addr)];
        end else begin
          reg_rdata <= READ_UNMAPPED;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Field aliases
  // ----------------------------------------------------------------------
  logic [7:0] phase_r;   // Buck clock phase register
  logic [7:0] outif_r;   // Output and interface register
  logic [7:0] bauto_r;   // Buck power-up auto register
  logic [7:0] lbyp_r;    // LDO bypass and auto register
  logic [7:0] lauto_r;   // LDO power-up auto register
  logic [7:0] join_r;    // Buck join and mode register
  logic       core_join; // Core bucks form one dual-phase buck
  logic       memio_join;// Mem and IO bucks share one coil

  assign phase_r    = cfg_q[IDX_PHASE];
  assign outif_r    = cfg_q[IDX_OUTIF];
  assign bauto_r    = cfg_q[IDX_BAUTO];
  assign lbyp_r     = cfg_q[IDX_LBYP];
  assign lauto_r    = cfg_q[IDX_LAUTO];
  assign join_r     = cfg_q[IDX_JOIN];
  assign core_join  = join_r[B_CORE_JOIN];
  assign memio_join = join_r[B_MEMIO_JOIN];

  // ----------------------------------------------------------------------
  // Buck clock phase and discharge
  // ----------------------------------------------------------------------
  // Proc versus mem phase is left as programmed; software pairs them
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      periph_buck_phase_flip <= 1'b0;
      io_buck_phase_flip     <= 1'b0;
      mem_buck_phase_flip    <= 1'b0;
      proc_buck_phase_flip   <= 1'b0;
      core_buck_a_phase_flip <= 1'b0;
      core_buck_b_phase_flip <= 1'b1;
      rail_active_drain      <= 1'b0;
    end else begin
      periph_buck_phase_flip <= phase_r[B_PERI_PHASE];
      // Joined IO buck follows the mem buck it shares a coil with
      io_buck_phase_flip     <= memio_join ? phase_r[B_MEM_PHASE]
                                           : phase_r[B_IO_PHASE];
      mem_buck_phase_flip    <= phase_r[B_MEM_PHASE];
      proc_buck_phase_flip   <= phase_r[B_PROC_PHASE];
      core_buck_a_phase_flip <= phase_r[B_CORE_PHASE];
      core_buck_b_phase_flip <= ~phase_r[B_CORE_PHASE];
      rail_active_drain      <= phase_r[B_DRAIN];
    end
  end

  // ----------------------------------------------------------------------
  // Feedback pins and sense routing
  // ----------------------------------------------------------------------
  logic fb2_taken;  // Feedback2 pin lent to the joined core sense line

  assign fb2_taken = core_join && !join_r[B_SENSE_RT];

  // Feedback3 is a plain push-pull level
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      feedback3_pin <= 1'b1;
    end else begin
      feedback3_pin <= outif_r[B_FB3_POL] ? feedback3_event : ~feedback3_event;
    end
  end

  // Feedback2 carries power-good; low polarity is push-pull, high polarity
  // is open drain and relies on an external pull-up
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      feedback2_pin_out  <= 1'b0;
      feedback2_pin_oe_n <= 1'b1;
    end else if (fb2_taken) begin
      feedback2_pin_out  <= 1'b0;  // Normal function off while sensing
      feedback2_pin_oe_n <= 1'b1;
    end else if (outif_r[B_FB2_POL]) begin
      feedback2_pin_out  <= 1'b0;
      feedback2_pin_oe_n <= power_good;    // Release to read high when good
    end else begin
      feedback2_pin_out  <= ~power_good;
      feedback2_pin_oe_n <= 1'b0;
    end
  end

  // Capacitor sense routing, only meaningful with joined core bucks
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sense_to_feedback2   <= 1'b0;
      sense_to_core_switch <= 1'b0;
    end else begin
      sense_to_feedback2   <= fb2_taken;
      sense_to_core_switch <= core_join && join_r[B_SENSE_RT];
    end
  end

  // ----------------------------------------------------------------------
  // Reset and interrupt outputs
  // ----------------------------------------------------------------------
  // Reset is held low during nrst so downstream logic never sees a
  // released reset before the bank is configured
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reset_out_n <= 1'b0;
    end else begin
      reset_out_n <= !(reset_request || outif_r[B_FORCE_RST]);
    end
  end

  // A deferred event stays pending and shows as soon as power is active
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= !(irq_pending && (power_active || !outif_r[B_IRQ_DEFER]));
    end
  end

  // ----------------------------------------------------------------------
  // Two-wire speed modes and system enable reload
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      permanent_high_speed <= 1'b0;
      fast_plus_timing     <= 1'b0;
    end else begin
      permanent_high_speed <= outif_r[B_HS_PERM];
      fast_plus_timing     <= outif_r[B_FAST_PLUS];
    end
  end

  // System enable only changes on the second OTP read, and only unguarded
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      system_en <= 1'b0;
    end else if (otp_second_read && !outif_r[B_SYSEN_KEEP]) begin
      system_en <= otp_system_en;
    end
  end

  // ----------------------------------------------------------------------
  // Power-up rail enables and LDO modes
  // ----------------------------------------------------------------------
  logic [7:0] buck_en_raw;  // Buck and switch enables with joining applied, before the register
  logic [4:0] ldo_auto;     // LDO3, 7, 8, 9, 11 auto bits in index order

  assign ldo_auto = {lbyp_r[B_LDO11_AUTO], lbyp_r[B_LDO9_AUTO], lauto_r[B_LDO8_AUTO],
                     lauto_r[B_LDO7_AUTO], lauto_r[B_LDO3_AUTO]};

  // Auto bits only force a rail on while powering up
  always_comb begin
    buck_en_raw = powering_up ? (bauto_r | buck_conf_en) : buck_conf_en;
    if (memio_join) begin
      buck_en_raw[RAIL_IO] = buck_en_raw[RAIL_MEM];
    end
    if (core_join) begin
      buck_en_raw[RAIL_CORE_B] = buck_en_raw[RAIL_CORE_A];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      buck_rail_en <= '0;
      ldo_rail_en  <= '0;
    end else begin
      buck_rail_en <= buck_en_raw;
      ldo_rail_en  <= powering_up ? (ldo_auto | ldo_conf_en) : ldo_conf_en;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ldo_bypass        <= '0;
      ldo8_motor_select <= 1'b0;
    end else begin
      ldo_bypass        <= {lbyp_r[B_LDO11_BYP], lbyp_r[B_LDO8_BYP],
                            lbyp_r[B_LDO7_BYP], lbyp_r[B_LDO3_BYP]};
      ldo8_motor_select <= join_r[B_LDO8_MOTOR];
    end
  end

  // ----------------------------------------------------------------------
  // Buck joining and full-current modes
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      io_buck_ctrl_off    <= 1'b0;
      core_b_ctrl_off     <= 1'b0;
      core_a_full_current <= 1'b0;
      core_b_full_current <= 1'b0;
      proc_full_current   <= 1'b0;
    end else begin
      io_buck_ctrl_off    <= memio_join;
      core_b_ctrl_off     <= core_join;
      core_a_full_current <= join_r[B_CORE_A_FC];
      core_b_full_current <= join_r[B_CORE_B_FC];
      proc_full_current   <= join_r[B_PROC_FC];
    end
  end

  // ----------------------------------------------------------------------
  // PWM clock
  // ----------------------------------------------------------------------
  pwm_tick_gen u_pwm_tick (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .slow_sel (join_r[B_PWM_SLOW]),
    .tick_q   (pwm_clk_tick),
    .period_q (pwm_period_tick)
  );

endmodule

`default_nettype wire

/* hdl/cfg_bank_pkg.sv */
// Constants shared by the configuration bank and its PWM tick divider.
// Assumes a single 100 MHz system clock and a byte-wide register port.
`default_nettype none

package cfg_bank_pkg;

  // ----------------------------------------------------------------------
  // Clock and PWM timing
  // ----------------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ   = 100_000_000;  // System clock rate
  localparam int unsigned PWM_FAST_HZ  = 2_000_000;    // PWM clock, select 0
  localparam int unsigned PWM_SLOW_HZ  = 1_000_000;    // PWM clock, select 1
  localparam int unsigned PWM_FAST_DIV = SYS_CLK_HZ / PWM_FAST_HZ;
  localparam int unsigned PWM_SLOW_DIV = SYS_CLK_HZ / PWM_SLOW_HZ;
  localparam int unsigned PWM_STEPS    = 64;           // Ticks per repetition

  // ----------------------------------------------------------------------
  // Register port geometry and map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W   = 9;                // Register address width
  localparam int unsigned DATA_W   = 8;                // Register data width
  localparam int unsigned NUM_REGS = 6;                // Registers in this bank
  localparam logic [8:0] ADDR_BUCK_CLOCK_PHASE_CFG     = 9'h108;
  localparam logic [8:0] ADDR_OUTPUT_AND_INTERFACE_CFG = 9'h109;
  localparam logic [8:0] ADDR_BUCK_POWERUP_AUTO_CFG    = 9'h10A;
  localparam logic [8:0] ADDR_LDO_BYPASS_AUTO_CFG      = 9'h10B;
  localparam logic [8:0] ADDR_LDO_POWERUP_AUTO_CFG     = 9'h10C;
  localparam logic [8:0] ADDR_BUCK_JOIN_MODE_CFG       = 9'h10D;

  // Register indices within the bank
  localparam int unsigned IDX_PHASE = 0;
  localparam int unsigned IDX_OUTIF = 1;
  localparam int unsigned IDX_BAUTO = 2;
  localparam int unsigned IDX_LBYP  = 3;
  localparam int unsigned IDX_LAUTO = 4;
  localparam int unsigned IDX_JOIN  = 5;

  // Reset value of every register; no documented value, plain zero
  localparam logic [7:0] CFG_RESET_VALUE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned B_PERI_PHASE = 7;
  localparam int unsigned B_IO_PHASE   = 6;
  localparam int unsigned B_MEM_PHASE  = 5;
  localparam int unsigned B_PROC_PHASE = 4;
  localparam int unsigned B_CORE_PHASE = 3;
  localparam int unsigned B_DRAIN      = 2;
  localparam int unsigned B_FB3_POL    = 7;
  localparam int unsigned B_FB2_POL    = 6;
  localparam int unsigned B_FORCE_RST  = 5;
  localparam int unsigned B_HS_PERM    = 4;
  localparam int unsigned B_FAST_PLUS  = 3;
  localparam int unsigned B_SYSEN_KEEP = 2;
  localparam int unsigned B_IRQ_DEFER  = 1;
  localparam int unsigned B_LDO11_BYP  = 7;
  localparam int unsigned B_LDO8_BYP   = 6;
  localparam int unsigned B_LDO7_BYP   = 5;
  localparam int unsigned B_LDO3_BYP   = 3;
  localparam int unsigned B_LDO11_AUTO = 2;
  localparam int unsigned B_LDO9_AUTO  = 0;
  localparam int unsigned B_LDO8_AUTO  = 7;
  localparam int unsigned B_LDO7_AUTO  = 6;
  localparam int unsigned B_LDO3_AUTO  = 2;
  localparam int unsigned B_MEMIO_JOIN = 7;
  localparam int unsigned B_CORE_A_FC  = 6;
  localparam int unsigned B_CORE_B_FC  = 5;
  localparam int unsigned B_PROC_FC    = 4;
  localparam int unsigned B_CORE_JOIN  = 3;
  localparam int unsigned B_SENSE_RT   = 2;
  localparam int unsigned B_LDO8_MOTOR = 1;
  localparam int unsigned B_PWM_SLOW   = 0;

  // Rail enable vector positions (same order as the buck auto register)
  localparam int unsigned RAIL_CORE_A = 0;
  localparam int unsigned RAIL_CORE_B = 1;
  localparam int unsigned RAIL_MEM    = 3;
  localparam int unsigned RAIL_IO     = 4;

endpackage

`default_nettype wire

/* hdl/pwm_tick_gen.sv */
// PWM clock enable divider: one-cycle ticks at 2 MHz or 1 MHz.
// Assumes sys_clk at the package rate; select may change at any time.
`default_nettype none

module pwm_tick_gen
  import cfg_bank_pkg::*;
#(
  parameter int unsigned FAST_DIV = PWM_FAST_DIV,
  parameter int unsigned SLOW_DIV = PWM_SLOW_DIV,
  parameter int unsigned STEPS    = PWM_STEPS
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic slow_sel,
  output var  logic tick_q,
  output var  logic period_q
);

  // ----------------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------------
  localparam int unsigned CNT_W  = $clog2(SLOW_DIV);
  localparam int unsigned STEP_W = $clog2(STEPS);
  localparam logic [CNT_W-1:0]  FAST_LAST = CNT_W'(FAST_DIV - 1);
  localparam logic [CNT_W-1:0]  SLOW_LAST = CNT_W'(SLOW_DIV - 1);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEPS - 1);

  logic [CNT_W-1:0]  cnt_q;     // Cycles within one PWM clock period
  logic [STEP_W-1:0] step_q;    // PWM clock ticks within one repetition
  logic              cnt_wrap;  // Last cycle of a PWM clock period

  // A select change mid-count just moves the wrap point; '>=' keeps the
  // counter from running past a shorter limit.
  assign cnt_wrap = (cnt_q >= (slow_sel ? SLOW_LAST : FAST_LAST));

  // Prescaler
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (cnt_wrap) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Repetition step counter and output pulses
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      step_q   <= '0;
      tick_q   <= 1'b0;
      period_q <= 1'b0;
    end else begin
      tick_q   <= cnt_wrap;
      period_q <= cnt_wrap && (step_q == STEP_LAST);
      if (cnt_wrap) begin
        step_q <= step_q + STEP_W'(1);
      end
    end
  end

endmodule

`default_nettype wire

/* verification/cfg_bank_assertions.sv */
// Checker on the bank ports: register port timing and control levels.
// Assumes a bind onto pmic_config_bank; one clock, sync reset nrst.
`default_nettype none
module cfg_bank_assertions (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic       reg_rvalid,
  input wire logic       core_buck_a_phase_flip,
  input wire logic       core_buck_b_phase_flip,
  input wire logic       rail_active_drain,
  input wire logic       reset_out_n,
  input wire logic       fast_plus_timing,
  input wire logic       irq_pending,
  input wire logic       power_active,
  input wire logic       interrupt_out_n,
  input wire logic       pwm_clk_tick,
  input wire logic       pwm_period_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] gap_q; // Cycles since the last PWM tick
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Restarts on each tick, so a stalled divider runs past the bound
  always_ff @(posedge sys_clk) begin
    if (!nrst || pwm_clk_tick) gap_q <= 8'h00;
    else gap_q <= gap_q + 8'h01;
  end
  // A write with bit b set, then a quiet cycle while it is stored
  sequence set_bit(a, b);
    reg_wr && reg_addr == a && reg_wdata[b] ##1 !reg_wr;
  endsequence
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe got no valid");
  a_core_opposite: assert property (core_buck_b_phase_flip != core_buck_a_phase_flip)
    else $error("core bucks share a phase");
  a_drain_on: assert property (set_bit(9'h108, 2) |=> rail_active_drain)
    else $error("drain bit had no effect");
  a_force_reset: assert property (set_bit(9'h109, 5) |=> !reset_out_n)
    else $error("forced reset not driven");
  a_fast_plus: assert property (set_bit(9'h109, 3) |=> fast_plus_timing)
    else $error("fast plus timing not selected");
  a_irq_idle: assert property (!irq_pending |=> interrupt_out_n)
    else $error("interrupt without a cause");
  a_irq_active: assert property (irq_pending && power_active |=> !interrupt_out_n)
    else $error("interrupt held back while active");
  a_period_tick: assert property (pwm_period_tick |-> pwm_clk_tick)
    else $error("period tick off the clock tick");
  a_tick_gap: assert property (gap_q < 8'h64)
    else $error("PWM tick gap too long");
endmodule
`default_nettype wire

/* verification/host_model.sv */
// Host model: single-byte writes and reads on the bank register port.
// Assumes a read answers with rvalid one cycle after the strobe edge.
`default_nettype none
module host_model (
  input  wire logic       sys_clk,
  output var  logic [8:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Only bench-chosen values go out: phases paired, joins used properly
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk) #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Released address shows its inverse so a stale value never matches
  task automatic rd(input logic [8:0] a, output logic [7:0] d, output logic v);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk) #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* verification/pmic_config_bank_c_to_h_tb.sv */
// Bench for the configuration bank: a table of writes, then corners.
// Assumes host_model on the register port and the checker bound below.
`default_nettype none
module pmic_config_bank_c_to_h_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [8:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic sys_clk = 0, nrst = 0, fb3_ev = 0, pgood = 1, rreq = 0, irq = 1, act = 0;
  logic otp_rd = 0, otp_en = 0, pup = 1, v;
  logic [7:0] bconf = 8'h00, rd_d;
  wire [8:0] addr;
  wire [7:0] wdata, rdata, brail;
  wire [4:0] lrail;
  wire [3:0] byp;
  wire [20:1] o; // Levels in the bit order that obs reads them
  wire wr, rd, rvalid, rst_n, irq_n, sysen, tick, ptick;
  int n_errors = 0, comparisons = 0, cyc = 0, n;
  row_t rows [9] = '{'{9'h108, 8'hEC, 8'hEC}, '{9'h108, 8'h13, 8'h12},
    '{9'h109, 8'hFA, 8'hFA}, '{9'h109, 8'h05, 8'h00}, '{9'h10A, 8'hA5, 8'hA5},
    '{9'h10B, 8'hFF, 8'hED}, '{9'h10C, 8'hFF, 8'hC4}, '{9'h10D, 8'h0C, 8'h0C},
    '{9'h10D, 8'hFA, 8'hFB}};
  host_model host_model_inst (.sys_clk, .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid));
  pmic_config_bank pmic_config_bank_inst (.sys_clk, .nrst, .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .periph_buck_phase_flip(o[7]), .io_buck_phase_flip(o[6]), .mem_buck_phase_flip(o[5]),
    .proc_buck_phase_flip(o[4]), .core_buck_a_phase_flip(o[3]), .rail_active_drain(o[2]),
    .core_buck_b_phase_flip(o[1]), .feedback3_event(fb3_ev), .feedback3_pin(o[8]),
    .power_good(pgood), .feedback2_pin_out(o[20]), .feedback2_pin_oe_n(o[9]),
    .sense_to_feedback2(o[12]), .sense_to_core_switch(o[14]), .reset_request(rreq),
    .reset_out_n(rst_n), .irq_pending(irq), .power_active(act), .interrupt_out_n(irq_n),
    .permanent_high_speed(o[11]), .fast_plus_timing(o[10]), .otp_second_read(otp_rd),
    .otp_system_en(otp_en), .system_en(sysen), .powering_up(pup), .buck_conf_en(bconf),
    .buck_rail_en(brail), .ldo_conf_en(5'h00), .ldo_rail_en(lrail), .ldo_bypass(byp),
    .io_buck_ctrl_off(o[19]), .core_b_ctrl_off(o[15]), .core_a_full_current(o[18]),
    .core_b_full_current(o[17]), .proc_full_current(o[16]), .ldo8_motor_select(o[13]),
    .pwm_clk_tick(tick), .pwm_period_tick(ptick));
  always #5 sys_clk = ~sys_clk;
  // Cycle ceiling well above the few thousand cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge sys_clk) #1;
    nrst = 0;
    repeat (4) @(posedge sys_clk);
    #1 nrst = 1;
  endtask
  // Cycles between two ticks of the chosen PWM strobe
  task automatic gap(input bit p, output int k);
    while ((p ? ptick : tick) !== 1'b1) @(posedge sys_clk) #1;
    @(posedge sys_clk) #1;
    k = 1;
    while ((p ? ptick : tick) !== 1'b1) begin
      @(posedge sys_clk) #1;
      k++;
    end
  endtask
  // Observed levels laid out in the bit order of each register
  function automatic logic [7:0] obs(logic [8:0] a);
    case (a)
      9'h108: return {o[7:1], 1'b0};
      9'h109: return {~o[8], o[9], ~rst_n, o[11:10], 1'b0, irq_n, 1'b0};
      9'h10A: return brail;
      9'h10B: return {byp[3:1], 1'b0, byp[0], lrail[4], 1'b0, lrail[3]};
      9'h10C: return {lrail[2:1], 3'h0, lrail[0], 2'h0};
      default: return o[19:12];
    endcase
  endfunction
  initial begin
    do_reset();
    foreach (rows[i]) begin
      host_model_inst.wr(rows[i].a, rows[i].d);
      host_model_inst.rd(rows[i].a, rd_d, v);
      chk("readback", rows[i].d, rd_d);
      chk("levels", rows[i].e, obs(rows[i].a));
    end
    $display("test rows done");
    do_reset();
    host_model_inst.wr(9'h10E, 8'hFF);
    host_model_inst.wr(9'h107, 8'hFF);
    for (int a = 9'h107; a <= 9'h10E; a++) begin
      host_model_inst.rd(a[8:0], rd_d, v);
      chk("reset or unmapped", 16'h0100, {v, rd_d});
    end
    fb3_ev = 1;
    pgood = 0;
    @(posedge sys_clk) #1;
    chk("fb3 pin", 16'h0000, o[8]);
    chk("irq now", 16'h0000, irq_n);
    chk("fb2 drive", 16'h0001, {o[9], o[20]});
    host_model_inst.wr(9'h109, 8'h02);
    @(posedge sys_clk) #1;
    chk("irq held", 16'h0001, irq_n);
    act = 1;
    otp_en = 1;
    otp_rd = 1;
    repeat (2) @(posedge sys_clk);
    #1 chk("irq late", 16'h0000, irq_n);
    chk("sys en load", 16'h0001, sysen);
    host_model_inst.wr(9'h109, 8'h06);
    otp_en = 0;
    repeat (3) @(posedge sys_clk);
    #1 chk("sys en kept", 16'h0001, sysen);
    otp_rd = 0;
    rreq = 1;
    repeat (2) @(posedge sys_clk);
    #1 chk("reset out", 16'h0000, rst_n);
    rreq = 0;
    irq = 0;
    pup = 0;
    bconf = 8'h09;
    host_model_inst.wr(9'h10D, 8'h88);
    host_model_inst.wr(9'h108, 8'h18);
    @(posedge sys_clk) #1;
    chk("joined rails", 16'h001B, brail);
    chk("core phases", 16'h0002, {o[3], o[1]});
    $display("test corners done");
    gap(0, n);
    chk("tick gap", 16'h0032, n[15:0]);
    gap(1, n);
    chk("period", 16'h0C80, n[15:0]);
    host_model_inst.wr(9'h10D, 8'h01);
    gap(0, n);
    gap(0, n);
    chk("slow gap", 16'h0064, n[15:0]);
    $display("test pwm done");
    stop_test();
  end
endmodule
bind pmic_config_bank cfg_bank_assertions chk_inst (.sys_clk, .nrst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rvalid, .core_buck_a_phase_flip, .core_buck_b_phase_flip,
  .rail_active_drain, .reset_out_n, .fast_plus_timing, .irq_pending, .power_active,
  .interrupt_out_n, .pwm_clk_tick, .pwm_period_tick);
`default_nettype wire
